// ===== rtl/pdm_port.sv
// Eight-pin port with drive modes, pin state, and edge interrupts
//
// Overview of operation
// - Each pin holds own three-bit drive selection
// - Drive from data bit or routed bypass
// - Selection 0: driver and input off
// - Selection 1: driver off, input on
// - Selections 2, 3, 7 resistive combinations
// - Selections 4, 5 open drain
// - Selection 6 strong both ways
// - Input stays usable in resistive, open drain
// - No resistive pulls under regulated output
// - Reset to analog high-Z, reset value programmable
// - Per-pin rising, falling, both or none
// - One interrupt request per port
// - Pin state separate from output data
// - Port-wise and pin-wise configuration access
// - Edge sets status bit and requests interrupt
// - Bidir switches high-Z digital and drive
`timescale 1ns/10ps
`default_nettype none
module pdm_port (
    input  wire logic        i_mclk,         // System clock, 100 MHz
    input  wire logic        i_nrst,         // Async reset, active low
    input  wire logic [23:0] i_rst_sel,      // Drive selection taken at reset release
    input  wire logic        i_port_wr,      // Port-wise configuration write
    input  wire logic [7:0]  i_port_drive_select_bit2, // Bit 2 of each pin's selection
    input  wire logic [7:0]  i_port_drive_select_bit1, // Bit 1 of each pin's selection
    input  wire logic [7:0]  i_port_drive_select_bit0, // Bit 0 of each pin's selection
    input  wire logic [7:0]  i_digital_route_select,   // Bypass per pin
    input  wire logic [7:0]  i_bidir_output_enable_select, // Bidir per pin
    input  wire logic        i_pin_wr,       // Pin-wise configuration write
    input  wire logic [2:0]  i_pin_idx,      // Pin addressed by pin-wise write
    input  wire logic [2:0]  i_pin_drive_select_bits, // Selection for that pin
    input  wire logic        i_pin_route,    // Bypass for that pin
    input  wire logic        i_pin_bidir,    // Bidir for that pin
    input  wire logic        i_pin_out,      // Output value for that pin
    input  wire logic        i_out_wr,       // Output value write
    input  wire logic [7:0]  i_output_value_write, // Output data written
    input  wire logic        i_edge_wr,      // Edge selection write
    input  wire logic [15:0] i_pin_edge_select, // Two bits per pin
    input  wire logic        i_flags_clr,    // Clear event flags
    input  wire logic [7:0]  i_flags_clr_mask, // Flags to clear
    input  wire logic [7:0]  i_route_data,   // Routed digital signals
    input  wire logic [7:0]  i_route_oe,     // Routed output enables
    input  wire logic [7:0]  i_regulated,    // Special pin in regulated mode
    input  wire logic [7:0]  i_pin_in,       // Pin levels
    output logic      [7:0]  o_port_output_value, // Output data register
    output logic      [23:0] o_drive_select_bits, // All selections
    output logic      [7:0]  o_pin_state_read, // Synchronised pin state
    output logic      [7:0]  o_pin_event_flags, // Sticky edge flags
    output logic             o_irq,          // Port interrupt request
    output logic      [7:0]  o_strong_hi,    // Strong high drivers
    output logic      [7:0]  o_strong_lo,    // Strong low drivers
    output logic      [7:0]  o_res_hi,       // Resistive pull-ups
    output logic      [7:0]  o_res_lo,       // Resistive pull-downs
    output logic      [7:0]  o_in_en         // Input buffer enables
);
    localparam int N = pdm_pkg::NUM_PINS;

    typedef struct packed {
        logic        loaded;
        logic [23:0] sel;
        logic [7:0]  byp;
        logic [7:0]  bidir;
        logic [7:0]  dout;
        logic [15:0] edge_sel;
        logic [7:0]  flags;
        logic [7:0]  state;
    } pdm_state_t;

    pdm_state_t st_r;
    pdm_state_t st_nxt;
    logic [7:0] ev;
    logic [7:0] lvl;
    logic [7:0] drv_data;
    logic [7:0] pin_sel;

    // One-hot decode of the pin-wise index
    function automatic logic [7:0] pin_hit(input logic [2:0] idx);
        pin_hit = 8'h01 << idx;
    endfunction

    assign pin_sel = pin_hit(i_pin_idx);

    always_comb begin
        st_nxt = st_r;
        // Strap taken one clock after release, never under async reset
        if (!st_r.loaded) begin
            st_nxt.loaded = 1'b1;
            st_nxt.sel    = i_rst_sel;
        end
        if (i_port_wr) begin
            for (int k = 0; k < N; k++) begin
                st_nxt.sel[3*k +: 3] = {i_port_drive_select_bit2[k],
                                        i_port_drive_select_bit1[k],
                                        i_port_drive_select_bit0[k]};
            end
            st_nxt.byp   = i_digital_route_select;
            st_nxt.bidir = i_bidir_output_enable_select;
        end
        if (i_pin_wr) begin
            for (int k = 0; k < N; k++) begin
                if (pin_sel[k]) begin
                    st_nxt.sel[3*k +: 3] = i_pin_drive_select_bits;
                    st_nxt.byp[k]   = i_pin_route;
                    st_nxt.bidir[k] = i_pin_bidir;
                    st_nxt.dout[k]  = i_pin_out;
                end
            end
        end
        // Port-wide output write takes priority over pin-wise data
        if (i_out_wr) begin
            st_nxt.dout = i_output_value_write;
        end
        if (i_edge_wr) begin
            st_nxt.edge_sel = i_pin_edge_select;
        end
        // Separate state register, never written by software
        st_nxt.state = lvl;
        // New events win over a clear in the same cycle
        st_nxt.flags = (st_r.flags & ~(i_flags_clr ? i_flags_clr_mask : 8'h00)) | ev;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r          <= '0;
            st_r.sel      <= {N{pdm_pkg::SEL_RST}};
            st_r.edge_sel <= {N{pdm_pkg::EDGE_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            pdm_drive_dec u_dec (
                .i_sel       (st_r.sel[3*g +: 3]),
                .i_data      (drv_data[g]),
                .i_oe        (i_route_oe[g]),
                .i_bidir     (st_r.bidir[g]),
                .i_regulated (i_regulated[g]),
                .o_strong_hi (o_strong_hi[g]),
                .o_strong_lo (o_strong_lo[g]),
                .o_res_hi    (o_res_hi[g]),
                .o_res_lo    (o_res_lo[g]),
                .o_in_en     (o_in_en[g])
            );
            pdm_edge_det u_edge (
                .i_mclk  (i_mclk),
                .i_nrst  (i_nrst),
                .i_pin   (i_pin_in[g]),
                .i_en    (o_in_en[g]),
                .i_edge  (st_r.edge_sel[2*g +: 2]),
                .o_level (lvl[g]),
                .o_event (ev[g])
            );
        end
    endgenerate

    assign drv_data            = (st_r.byp & i_route_data) | (~st_r.byp & st_r.dout);
    assign o_port_output_value = st_r.dout;
    assign o_drive_select_bits = st_r.sel;
    assign o_pin_state_read    = st_r.state;
    assign o_pin_event_flags   = st_r.flags;
    assign o_irq               = |st_r.flags;
endmodule
`default_nettype wire

// ===== rtl/pdm_pkg.sv
// Package of constants and types for the pin drive mode port
package pdm_pkg;
    localparam int          NUM_PINS    = 8;
    localparam int          SEL_W       = 3;
    localparam logic [2:0]  SEL_HIZ_ANA = 3'h0;
    localparam logic [2:0]  SEL_HIZ_DIG = 3'h1;
    localparam logic [2:0]  SEL_RES_UP  = 3'h2;
    localparam logic [2:0]  SEL_RES_DN  = 3'h3;
    localparam logic [2:0]  SEL_OD_LOW  = 3'h4;
    localparam logic [2:0]  SEL_OD_HIGH = 3'h5;
    localparam logic [2:0]  SEL_STRONG  = 3'h6;
    localparam logic [2:0]  SEL_RES_UD  = 3'h7;
    localparam logic [2:0]  SEL_RST     = 3'h0;
    localparam logic [1:0]  EDGE_NONE   = 2'h0;
    localparam logic [1:0]  EDGE_RISE   = 2'h1;
    localparam logic [1:0]  EDGE_FALL   = 2'h2;
    localparam logic [1:0]  EDGE_BOTH   = 2'h3;
    localparam logic [1:0]  EDGE_RST    = 2'h0;

    // Per-pin drive controls produced by the decoder
    typedef struct packed {
        logic strong_hi;
        logic strong_lo;
        logic res_hi;
        logic res_lo;
        logic in_en;
    } pdm_drive_t;
endpackage

// ===== rtl/pdm_drive_dec.sv
// Drive mode decoder for one pin
`timescale 1ns/10ps
`default_nettype none
module pdm_drive_dec (
    input  wire logic [2:0] i_sel,       // Drive selection
    input  wire logic       i_data,      // Output data value
    input  wire logic       i_oe,        // Routed output enable (bidir)
    input  wire logic       i_bidir,     // Bidirectional mode enabled
    input  wire logic       i_regulated, // Special pin in regulated mode
    output logic            o_strong_hi, // Strong high driver on
    output logic            o_strong_lo, // Strong low driver on
    output logic            o_res_hi,    // Resistive pull-up on
    output logic            o_res_lo,    // Resistive pull-down on
    output logic            o_in_en      // Input buffer enabled
);
    logic       act;
    logic       res_ok;
    always_comb begin
        // Bidir releases to digital high impedance while oe is low
        act    = !i_bidir || i_oe;
        // Resistive pulls are withheld under regulated output
        res_ok = !i_regulated;
        o_strong_hi = 1'b0;
        o_strong_lo = 1'b0;
        o_res_hi    = 1'b0;
        o_res_lo    = 1'b0;
        o_in_en     = (i_sel != pdm_pkg::SEL_HIZ_ANA);
        if (act) begin
            unique case (i_sel)
                pdm_pkg::SEL_HIZ_ANA, pdm_pkg::SEL_HIZ_DIG: begin
                end
                pdm_pkg::SEL_RES_UP: begin
                    o_res_hi    = i_data && res_ok;
                    o_strong_lo = !i_data;
                end
                pdm_pkg::SEL_RES_DN: begin
                    o_strong_hi = i_data;
                    o_res_lo    = !i_data && res_ok;
                end
                pdm_pkg::SEL_OD_LOW: begin
                    o_strong_lo = !i_data;
                end
                pdm_pkg::SEL_OD_HIGH: begin
                    o_strong_hi = i_data;
                end
                pdm_pkg::SEL_STRONG: begin
                    o_strong_hi = i_data;
                    o_strong_lo = !i_data;
                end
                pdm_pkg::SEL_RES_UD: begin
                    o_res_hi = i_data && res_ok;
                    o_res_lo = !i_data && res_ok;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pdm_edge_det.sv
// Synchroniser and edge detector for one pin input
`timescale 1ns/10ps
`default_nettype none
module pdm_edge_det (
    input  wire logic       i_mclk,  // System clock
    input  wire logic       i_nrst,  // Async reset, active low
    input  wire logic       i_pin,   // Raw pin level
    input  wire logic       i_en,    // Input buffer enabled
    input  wire logic [1:0] i_edge,  // Edge selection
    output logic            o_level, // Synchronised level
    output logic            o_event  // One-cycle qualifying edge
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } pdm_sync_t;
    pdm_sync_t st_r;
    pdm_sync_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = i_pin & i_en;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_level = st_r.s2;
    // Edge is taken between the two stable stages, so one transition gives one pulse
    always_comb begin
        unique case (i_edge)
            pdm_pkg::EDGE_NONE: o_event = 1'b0;
            pdm_pkg::EDGE_RISE: o_event = st_r.s2 & ~st_r.s3;
            pdm_pkg::EDGE_FALL: o_event = ~st_r.s2 & st_r.s3;
            pdm_pkg::EDGE_BOTH: o_event = st_r.s2 ^ st_r.s3;
        endcase
    end
endmodule
`default_nettype wire

// ===== sim/pdm_pin_model.sv
// Board model that resolves each pin level
`timescale 1ns/10ps
`default_nettype none
module pdm_pin_model (
    input  wire logic       i_mclk,    // Clock
    input  wire logic [7:0] i_shi,     // Strong high
    input  wire logic [7:0] i_slo,     // Strong low
    input  wire logic [7:0] i_rhi,     // Pull-up
    input  wire logic [7:0] i_rlo,     // Pull-down
    input  wire logic [7:0] i_ext_en,  // Board drives
    input  wire logic [7:0] i_ext_val, // Board level
    output logic      [7:0] o_pin      // Pin level
);
    logic tog_r = 1'b0;
    // Undriven pins wander so a stale level is never read back
    always @(posedge i_mclk) tog_r <= ~tog_r;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            o_pin[k] = (i_shi[k] | i_slo[k]) ? i_shi[k] : i_ext_en[k] ? i_ext_val[k] :
                       (i_rhi[k] | i_rlo[k]) ? i_rhi[k] : tog_r;
        end
    end
endmodule
`default_nettype wire

// ===== sim/pdm_port_chk.sv
// Assertion checker for the pin drive mode port
`timescale 1ns/10ps
`default_nettype none
module pdm_port_chk (
    input wire logic        i_mclk,              // Clock
    input wire logic        i_nrst,              // Reset
    input wire logic [23:0] i_rst_sel,           // Strap
    input wire logic        i_port_wr,           // Port write
    input wire logic        i_pin_wr,            // Pin write
    input wire logic        i_out_wr,            // Data write
    input wire logic [7:0]  i_output_value_write, // Data
    input wire logic [7:0]  i_route_oe,          // Bidir enables
    input wire logic [7:0]  i_regulated,         // Regulated
    input wire logic [7:0]  i_pin_in,            // Pins
    input wire logic [7:0]  o_port_output_value, // Data reg
    input wire logic [23:0] o_drive_select_bits, // Selections
    input wire logic [7:0]  o_pin_state_read,    // State
    input wire logic [7:0]  o_pin_event_flags,   // Flags
    input wire logic        o_irq,               // Request
    input wire logic [7:0]  o_strong_hi,         // Drivers
    input wire logic [7:0]  o_strong_lo,         // Drivers
    input wire logic [7:0]  o_res_hi,            // Pulls
    input wire logic [7:0]  o_res_lo,            // Pulls
    input wire logic [7:0]  o_in_en              // Inputs
);
    logic [2:0] s0;
    logic [4:0] p0;
    assign s0 = o_drive_select_bits[2:0];
    assign p0 = {o_strong_hi[0], o_strong_lo[0], o_res_hi[0], o_res_lo[0], o_in_en[0]};
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // Synchroniser needs a few quiet cycles before state is meaningful
    sequence settled;
        ($stable(o_in_en) && $stable(i_pin_in))[*5];
    endsequence
    a_off_sel0: assert property (s0 == 3'h0 |-> p0 == 5'h00)
        else $error("pin active in selection 0");
    a_hiz_digital: assert property (s0 == 3'h1 |-> p0 == 5'h01)
        else $error("selection 1 wrong");
    a_strong_both: assert property (s0 == 3'h6 && i_route_oe[0] |-> p0[4] != p0[3] && p0[2:1] == 2'h0)
        else $error("strong drive wrong");
    a_no_fight: assert property ((o_strong_hi & o_strong_lo) == 8'h00)
        else $error("both strong drivers on");
    a_regulated_pull: assert property ((i_regulated & (o_res_hi | o_res_lo)) == 8'h00)
        else $error("pull under regulation");
    a_irq_flags: assert property (o_irq == (o_pin_event_flags != 8'h00))
        else $error("request not flag OR");
    a_reset_strap: assert property (!$past(i_nrst) && !i_port_wr && !i_pin_wr |=> o_drive_select_bits == $past(i_rst_sel))
        else $error("strap not loaded");
    a_state_sync: assert property (settled |-> o_pin_state_read == (i_pin_in & o_in_en))
        else $error("pin state wrong");
    a_no_spurious: assert property (settled |=> (o_pin_event_flags & ~$past(o_pin_event_flags)) == 8'h00)
        else $error("flag without edge");
    a_out_write: assert property (i_out_wr |=> o_port_output_value == $past(i_output_value_write))
        else $error("data write lost");
endmodule
bind pdm_port pdm_port_chk chk_u (.i_mclk, .i_nrst, .i_rst_sel, .i_port_wr, .i_pin_wr, .i_out_wr,
    .i_output_value_write, .i_route_oe, .i_regulated, .i_pin_in, .o_port_output_value, .o_drive_select_bits,
    .o_pin_state_read, .o_pin_event_flags, .o_irq, .o_strong_hi, .o_strong_lo, .o_res_hi, .o_res_lo, .o_in_en);
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the pin drive mode port
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        i_mclk = 1'b0, i_nrst = 1'b0, i_port_wr = 1'b0, i_pin_wr = 1'b0, i_pin_route = 1'b0;
    logic        i_pin_bidir = 1'b0, i_pin_out = 1'b0, i_out_wr = 1'b0, i_edge_wr = 1'b0, i_flags_clr = 1'b0;
    logic [23:0] i_rst_sel = 24'hFAC688;
    logic [2:0]  i_pin_idx = 3'h0, i_pin_drive_select_bits = 3'h0;
    logic [7:0]  b2 = 8'h00, b1 = 8'h00, b0 = 8'h00, rsel = 8'h00, bsel = 8'h00, dout = 8'h00, clr_m = 8'h00;
    logic [7:0]  rdat = 8'h00, roe = 8'h00, reg_m = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0]  pin, pov, psr, flg, shi, slo, rhi, rlo, ien;
    logic [15:0] esel = 16'h0000;
    logic [23:0] dsb;
    logic        irq;
    int          bad_count = 0, cmp_count = 0, cyc_n = 0;
    always #5 i_mclk = ~i_mclk;
    pdm_port dut_u (.i_mclk, .i_nrst, .i_rst_sel, .i_port_wr, .i_port_drive_select_bit2(b2),
        .i_port_drive_select_bit1(b1), .i_port_drive_select_bit0(b0), .i_digital_route_select(rsel),
        .i_bidir_output_enable_select(bsel), .i_pin_wr, .i_pin_idx, .i_pin_drive_select_bits, .i_pin_route,
        .i_pin_bidir, .i_pin_out, .i_out_wr, .i_output_value_write(dout), .i_edge_wr, .i_pin_edge_select(esel),
        .i_flags_clr, .i_flags_clr_mask(clr_m), .i_route_data(rdat), .i_route_oe(roe), .i_regulated(reg_m),
        .i_pin_in(pin), .o_port_output_value(pov), .o_drive_select_bits(dsb), .o_pin_state_read(psr),
        .o_pin_event_flags(flg), .o_irq(irq), .o_strong_hi(shi), .o_strong_lo(slo), .o_res_hi(rhi),
        .o_res_lo(rlo), .o_in_en(ien));
    pdm_pin_model brd_u (.i_mclk, .i_shi(shi), .i_slo(slo), .i_rhi(rhi), .i_rlo(rlo), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_pin(pin));
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    task automatic final_report;
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic port_wr(input logic [7:0] p2, p1, p0, rs, bs);
        @(posedge i_mclk);
        {b2, b1, b0, rsel, bsel} <= {p2, p1, p0, rs, bs};
        i_port_wr <= 1'b1;
        @(posedge i_mclk);
        i_port_wr <= 1'b0;
    endtask
    task automatic dwr(input logic [7:0] d);
        @(posedge i_mclk);
        dout <= d;
        i_out_wr <= 1'b1;
        @(posedge i_mclk);
        i_out_wr <= 1'b0;
    endtask
    task automatic clr(input logic [7:0] m);
        @(posedge i_mclk);
        clr_m <= m;
        i_flags_clr <= 1'b1;
        @(posedge i_mclk);
        i_flags_clr <= 1'b0;
    endtask
    // Returns {strong hi, strong lo, pull-up, pull-down, input on}
    function automatic logic [4:0] dm(input logic [2:0] s, input logic d);
        case (s)
            3'h0: return 5'h00;
            3'h1: return 5'h01;
            3'h2: return d ? 5'h05 : 5'h09;
            3'h3: return d ? 5'h11 : 5'h03;
            3'h4: return d ? 5'h01 : 5'h09;
            3'h5: return d ? 5'h11 : 5'h01;
            3'h6: return d ? 5'h11 : 5'h09;
            default: return d ? 5'h05 : 5'h03;
        endcase
    endfunction
    task automatic t_modes;
        logic [39:0] ev;
        logic [4:0]  r;
        for (int d = 1; d >= 0; d--) begin
            dwr({8{d[0]}});
            w(1);
            for (int k = 0; k < 8; k++) begin
                r = dm(k[2:0], d[0]);
                for (int b = 0; b < 5; b++) ev[8*b+k] = r[b];
            end
            chk({shi, slo, rhi, rlo, ien}, ev);
        end
        // Checked at both data values so pull-ups and pull-downs are each exercised
        @(posedge i_mclk) reg_m <= 8'hFF;
        w(1);
        chk(40'({rhi, rlo}), 40'h0);
        dwr(8'hFF);
        w(1);
        chk(40'({rhi, rlo}), 40'h0);
        @(posedge i_mclk) reg_m <= 8'h00;
    endtask
    task automatic t_pin;
        @(posedge i_mclk);
        {i_pin_idx, i_pin_drive_select_bits, i_pin_route, i_pin_bidir, i_pin_out} <= 9'h0F4;
        rdat <= 8'h08;
        i_pin_wr <= 1'b1;
        @(posedge i_mclk) i_pin_wr <= 1'b0;
        w(1);
        chk(40'({dsb[11:9], shi[3], slo[3], pov[3]}), 40'h34);
        @(posedge i_mclk) rdat <= 8'h00;
        w(1);
        chk(40'({shi[3], slo[3]}), 40'h1);
        dwr(8'h0F);
        port_wr(8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF);
        w(1);
        chk({dsb, shi, slo}, 40'hDB6DB60000);
        @(posedge i_mclk) roe <= 8'hFF;
        w(1);
        chk(40'({shi, slo, ien}), 40'h0FF0FF);
    endtask
    task automatic t_edges;
        port_wr(8'h00, 8'h00, 8'hFF, 8'h00, 8'h00);
        @(posedge i_mclk);
        {esel, ext_en, ext_val} <= 32'hE4E4FF00;
        i_edge_wr <= 1'b1;
        @(posedge i_mclk) i_edge_wr <= 1'b0;
        // Let the switch-over edges drain through the synchroniser before clearing
        w(6);
        clr(8'hFF);
        @(posedge i_mclk) ext_val <= 8'hFF;
        w(5);
        chk(40'({psr, flg, irq}), 40'({8'hFF, 8'hAA, 1'b1}));
        clr(8'hFF);
        w(1);
        chk(40'({flg, irq}), 40'h0);
        @(posedge i_mclk) ext_val <= 8'h00;
        w(5);
        chk(40'(flg), 40'hCC);
        clr(8'h0F);
        w(1);
        chk(40'({flg, irq}), 40'h181);
        clr(8'hFF);
        port_wr(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        @(posedge i_mclk) ext_val <= 8'hFF;
        w(5);
        chk(40'({psr, flg, ien}), 40'h0);
    endtask
    always @(posedge i_mclk) begin
        cyc_n++;
        if (cyc_n == 2000) begin
            bad_count++;
            final_report;
        end
    end
    initial begin
        repeat (8) @(posedge i_mclk);
        chk({shi, slo, rhi, rlo, ien}, 40'h0);
        i_nrst <= 1'b1;
        w(2);
        chk(40'(dsb), 40'hFAC688);
        t_modes;
        t_pin;
        t_edges;
        final_report;
    end
endmodule
`default_nettype wire
